/* logic/fcp_regs.svh */
// register offsets, field positions and address constants of the flash config/protection block
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH
// printed offsets are not byte addresses: they are indices, byte address is four times the index
`define FCP_IDX_CONFIG 4'h3
`define FCP_IDX_PROT 4'h4
`define FCP_IDX_STATUS 4'h5
`define FCP_IDX_SECURITY 4'h1
`define FCP_IDX_LOADCTL 4'h6
`define FCP_IDX_CMDADDR 4'h7
`define FCP_IDX_CMDCTL 4'h8
`define FCP_IDX_ARRAY 4'h9
// field positions
`define FCP_CFG_BEIE 7
`define FCP_CFG_ALL_DONE_IRQ_ENABLE 6
`define FCP_CFG_KEY_WRITE_GATE 5
`define FCP_PROT_POL 7
`define FCP_PROT_NV6 6
`define FCP_PROT_HDIS 5
`define FCP_PROT_HS_HI 4
`define FCP_PROT_HS_LO 3
`define FCP_PROT_LDIS 2
`define FCP_PROT_LS_HI 1
`define FCP_PROT_LS_LO 0
`define FCP_STAT_BEF 7
`define FCP_STAT_CCF 6
`define FCP_STAT_PROTECT_VIOLATION_FLAG 5
// values
`define FCP_CFG_MASK 8'hE0
`define FCP_KEY_ENABLED 2'h2
`define FCP_PROT_STORE_ADDR 16'hFF0D
`define FCP_CFG_RESET 8'h00
`define FCP_PROT_RESET 8'hFF
`define FCP_HIGH_TOP 16'hFFFF
`define FCP_HIGH_BASE0 16'hF800
`define FCP_HIGH_BASE1 16'hF000
`define FCP_HIGH_BASE2 16'hE000
`define FCP_HIGH_BASE3 16'hC000
`define FCP_LOW_BASE 16'h4000
`define FCP_LOW_END0 16'h41FF
`define FCP_LOW_END1 16'h43FF
`define FCP_LOW_END2 16'h47FF
`define FCP_LOW_END3 16'h4FFF
// command codes on the check port
`define FCP_CMD_PROGRAM 2'h1
`define FCP_CMD_SECTOR_ERASE 2'h2
`define FCP_CMD_MASS_ERASE 2'h3
`endif

/* logic/fcp_pkg.sv */
// types shared by the flash config/protection block
package fcp_pkg;
  typedef enum logic [1:0] {
    FCP_LD_IDLE = 2'b00,
    FCP_LD_WAIT = 2'b01,
    FCP_LD_DONE = 2'b10
  } fcp_load_e;
  typedef struct packed {
    logic pol;
    logic nv6;
    logic hdis;
    logic [1:0] hsize;
    logic ldis;
    logic [1:0] lsize;
  } fcp_prot_s;
  typedef struct packed {
    logic beie;
    logic all_done_irq_enable;
    logic key_write_gate;
  } fcp_cfg_s;
endpackage : fcp_pkg

/* logic/fcp_scenario.sv */
`timescale 1ns/1ps
// protection scenario number and allowed-transition check, registered
module fcp_scenario
  import fcp_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // current and proposed protection values
  input wire fcp_prot_s cur,
  input wire fcp_prot_s prop,
  // verdict
  output logic allowed
);
  function automatic logic [2:0] scen(input fcp_prot_s p);
    scen = {p.pol, p.hdis, p.ldis};
  endfunction : scen
  // scenario transition table: bit [to] set where the move is allowed
  function automatic logic [7:0] row(input logic [2:0] from);
    case (from)
      3'h0: row = 8'h0F;
      3'h1: row = 8'h0A;
      3'h2: row = 8'h0C;
      3'h3: row = 8'h08;
      3'h4: row = 8'h18;
      3'h5: row = 8'h3C;
      3'h6: row = 8'h5A;
      default: row = 8'hFF;
    endcase
  endfunction : row
  wire logic [2:0] from_s = scen(cur);
  wire logic [2:0] to_s = scen(prop);
  wire logic [7:0] ok_row = row(from_s);
  wire logic next_allowed = ok_row[to_s];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      allowed <= 1'b0;
    end else begin
      allowed <= next_allowed;
    end
  end
endmodule : fcp_scenario

/* logic/fcp_regs_top.sv */
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "fcp_regs.svh"
// flash configuration and protection registers with APB slave and protection checker
//
// Overview of operation
// - config bit 7 enables interrupt while buffer-empty flag set.
// - config bit 6 enables interrupt while command-complete flag set.
// - only the two enables and key gate are stored; other config bits read zero.
// - key gate writable only while backdoor field is enabled.
// - key gate set: array writes captured as key words, reads return junk.
// - protection register readable in every mode.
// - polarity bit can go from one to zero only.
// - low size writable only while low disable bit set.
// - high size writable only while high disable bit set.
// - protection register loaded from stored byte at 0xFF0D during reset sequence.
// - program or erase into protected area is refused and flags violation.
// - mass erase only with polarity and both disables set, else violation.
// - polarity chooses whether cleared disable bits protect or unprotect ranges.
// - high disable bit zero activates high range, one defines none.
// - low disable bit zero activates low range, one defines none.
// - high size selects range ending at top, 00 smallest to 11 largest.
// - low size selects range from array base, 00 smallest to 11 largest.
// - write moving protection to a disallowed scenario is ignored.
// - only backdoor field encoding 10 counts as enabled.
module fcp_regs_top
  import fcp_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // status and security inputs from the command controller
  input wire logic buffer_empty_flag,
  input wire logic all_done_flag,
  input wire logic [1:0] backdoor_enable_field,
  // reset-sequence load from the array
  input wire logic load_req,
  input wire logic [7:0] load_data,
  output logic load_done,
  // command check port
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_addr,
  output logic cmd_ok,
  output logic cmd_refused,
  output logic protect_violation_flag,
  // array access steering
  input wire logic array_wr,
  input wire logic array_rd,
  output logic key_word_strobe,
  output logic cmd_seq_start,
  output logic array_rd_invalid,
  // interrupt
  output logic irq
);
  fcp_cfg_s cfg;
  fcp_prot_s prot;
  fcp_prot_s prot_prop;
  fcp_load_e ld_state;
  fcp_load_e next_ld_state;
  logic wr_pend;
  logic scen_ok;

  // address decode: word index is paddr[5:2]
  wire logic [3:0] idx = paddr[5:2];
  wire logic aligned = (paddr[1:0] == 2'h0) && (paddr[7:6] == 2'h0);
  wire logic sel_cfg = aligned && (idx == `FCP_IDX_CONFIG);
  wire logic sel_prot = aligned && (idx == `FCP_IDX_PROT);
  wire logic sel_stat = aligned && (idx == `FCP_IDX_STATUS);
  wire logic sel_sec = aligned && (idx == `FCP_IDX_SECURITY);
  wire logic mapped = sel_cfg || sel_prot || sel_stat || sel_sec;
  // protection writes take one extra cycle so the scenario check is registered
  wire logic setup = psel && !penable;
  wire logic access = psel && penable;
  wire logic done_cycle = access && (!(pwrite && sel_prot) || wr_pend);
  wire logic wr_cfg = done_cycle && pwrite && sel_cfg;
  wire logic wr_prot = done_cycle && pwrite && sel_prot && ld_state == FCP_LD_DONE;
  wire logic [7:0] wd = pwdata[7:0];

  wire logic key_on = (backdoor_enable_field == `FCP_KEY_ENABLED);
  wire logic next_key_write_gate = key_on ? wd[`FCP_CFG_KEY_WRITE_GATE] : cfg.key_write_gate;
  wire fcp_cfg_s next_cfg = '{beie: wd[`FCP_CFG_BEIE], all_done_irq_enable: wd[`FCP_CFG_ALL_DONE_IRQ_ENABLE], key_write_gate: next_key_write_gate};

  // proposed protection: polarity may only clear, size fields locked once their disable is clear
  assign prot_prop.pol = prot.pol & wd[`FCP_PROT_POL];
  assign prot_prop.nv6 = prot.nv6;
  assign prot_prop.hdis = wd[`FCP_PROT_HDIS];
  assign prot_prop.hsize = prot.hdis ? wd[`FCP_PROT_HS_HI:`FCP_PROT_HS_LO] : prot.hsize;
  assign prot_prop.ldis = wd[`FCP_PROT_LDIS];
  assign prot_prop.lsize = prot.ldis ? wd[`FCP_PROT_LS_HI:`FCP_PROT_LS_LO] : prot.lsize;

  fcp_scenario i_fcp_scenario (
    .pclk(pclk),
    .presetn(presetn),
    .cur(prot),
    .prop(prot_prop),
    .allowed(scen_ok)
  );

  // range decode
  function automatic logic [15:0] high_base(input logic [1:0] s);
    case (s)
      2'h0: high_base = `FCP_HIGH_BASE0;
      2'h1: high_base = `FCP_HIGH_BASE1;
      2'h2: high_base = `FCP_HIGH_BASE2;
      default: high_base = `FCP_HIGH_BASE3;
    endcase
  endfunction : high_base
  function automatic logic [15:0] low_end(input logic [1:0] s);
    case (s)
      2'h0: low_end = `FCP_LOW_END0;
      2'h1: low_end = `FCP_LOW_END1;
      2'h2: low_end = `FCP_LOW_END2;
      default: low_end = `FCP_LOW_END3;
    endcase
  endfunction : low_end
  wire logic in_high = (cmd_addr >= high_base(prot.hsize));
  wire logic in_low = (cmd_addr >= `FCP_LOW_BASE) && (cmd_addr <= low_end(prot.lsize));
  wire logic high_act = !prot.hdis;
  wire logic low_act = !prot.ldis;
  wire logic in_range = (high_act && in_high) || (low_act && in_low);
  // polarity set: active ranges protected; clear: everything outside active ranges protected
  wire logic addr_prot = prot.pol ? in_range : !in_range;
  wire logic mass_ok = prot.pol && prot.hdis && prot.ldis;
  wire logic is_mass = (cmd_kind == `FCP_CMD_MASS_ERASE);
  wire logic refuse = is_mass ? !mass_ok : addr_prot;
  wire logic clr_viol = done_cycle && pwrite && sel_stat && wd[`FCP_STAT_PROTECT_VIOLATION_FLAG];
  wire logic next_viol = (cmd_valid && refuse) || (protect_violation_flag && !clr_viol);
  wire logic next_irq = (cfg.beie && buffer_empty_flag) || (cfg.all_done_irq_enable && all_done_flag);

  // reset-sequence load
  always_comb begin
    next_ld_state = ld_state;
    case (ld_state)
      FCP_LD_IDLE: next_ld_state = FCP_LD_WAIT;
      FCP_LD_WAIT: if (load_req) next_ld_state = FCP_LD_DONE;
      FCP_LD_DONE: next_ld_state = FCP_LD_DONE;
      default: next_ld_state = FCP_LD_IDLE;
    endcase
  end

  wire logic [7:0] prot_byte = prot;
  wire logic [7:0] cfg_byte = {cfg, 5'h00};
  wire logic [7:0] stat_byte = {buffer_empty_flag, all_done_flag, protect_violation_flag, 5'h00};
  wire logic [7:0] sec_byte = {backdoor_enable_field, 6'h00};
  wire logic [7:0] rd_byte = sel_cfg ? cfg_byte : sel_prot ? prot_byte : sel_stat ? stat_byte :
                             sel_sec ? sec_byte : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state <= FCP_LD_IDLE;
      load_done <= 1'b0;
    end else begin
      ld_state <= next_ld_state;
      load_done <= (next_ld_state == FCP_LD_DONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot <= `FCP_PROT_RESET;
    end else if (ld_state == FCP_LD_WAIT && load_req) begin
      prot <= load_data;
    end else if (wr_prot && scen_ok) begin
      prot <= prot_prop;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= fcp_cfg_s'(`FCP_CFG_RESET >> `FCP_CFG_KEY_WRITE_GATE);
    end else if (wr_cfg) begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pend <= 1'b0;
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      wr_pend <= access && pwrite && sel_prot && !wr_pend;
      pready <= setup ? !(pwrite && sel_prot) : (access && !done_cycle);
      prdata <= (setup || access) && !pwrite ? {24'h000000, rd_byte} : 32'h00000000;
      pslverr <= (setup || access) && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      protect_violation_flag <= 1'b0;
      cmd_ok <= 1'b0;
      cmd_refused <= 1'b0;
      irq <= 1'b0;
      key_word_strobe <= 1'b0;
      cmd_seq_start <= 1'b0;
      array_rd_invalid <= 1'b0;
    end else begin
      protect_violation_flag <= next_viol;
      cmd_ok <= cmd_valid && !refuse;
      cmd_refused <= cmd_valid && refuse;
      irq <= next_irq;
      key_word_strobe <= array_wr && cfg.key_write_gate;
      cmd_seq_start <= array_wr && !cfg.key_write_gate;
      array_rd_invalid <= array_rd && cfg.key_write_gate;
    end
  end

  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // interrupt
  irq_follow_a: assert property (
    next_irq |=> irq
  ) else $error("irq missed enabled source");
  irq_drop_a: assert property (
    !next_irq |=> !irq
  ) else $error("irq without source");
  irq_quiet_a: assert property (
    !cfg.beie && !cfg.all_done_irq_enable |=> !irq
  ) else $error("irq without enable");
  irq_empty_a: assert property (
    cfg.beie && buffer_empty_flag |=> irq
  ) else $error("buffer empty irq missed");
  irq_done_a: assert property (
    cfg.all_done_irq_enable && all_done_flag |=> irq
  ) else $error("command complete irq missed");
  // configuration and key gate
  cfg_write_a: assert property (
    wr_cfg |=> cfg.beie == $past(wd[`FCP_CFG_BEIE]) && cfg.all_done_irq_enable == $past(wd[`FCP_CFG_ALL_DONE_IRQ_ENABLE])
  ) else $error("interrupt enable not written");
  cfg_read_a: assert property (
    setup && !pwrite && sel_cfg |=> prdata == {24'h000000, prdata[7:0] & `FCP_CFG_MASK}
  ) else $error("unused config bits read nonzero");
  key_lock_a: assert property (
    wr_cfg && !key_on |=> $stable(cfg.key_write_gate)
  ) else $error("key gate written while disabled");
  key_pass_a: assert property (
    wr_cfg && key_on |=> cfg.key_write_gate == $past(wd[`FCP_CFG_KEY_WRITE_GATE])
  ) else $error("key gate write lost");
  key_enc_a: assert property (
    wr_cfg && backdoor_enable_field != `FCP_KEY_ENABLED |=> $stable(cfg.key_write_gate)
  ) else $error("key gate taken with disabled encoding");
  // array steering
  key_steer_a: assert property (
    array_wr && cfg.key_write_gate |=> key_word_strobe && !cmd_seq_start
  ) else $error("key word not captured");
  cmd_steer_a: assert property (
    array_wr && !cfg.key_write_gate |=> cmd_seq_start && !key_word_strobe
  ) else $error("command sequence not started");
  rd_junk_a: assert property (
    array_rd |=> array_rd_invalid == $past(cfg.key_write_gate)
  ) else $error("array read validity wrong");
  // protection register
  pol_clear_a: assert property (
    !prot.pol && ld_state == FCP_LD_DONE |=> !prot.pol
  ) else $error("polarity set by software");
  lsize_lock_a: assert property (
    !prot.ldis && ld_state == FCP_LD_DONE |=> $stable(prot.lsize)
  ) else $error("low size changed while locked");
  hsize_lock_a: assert property (
    !prot.hdis && ld_state == FCP_LD_DONE |=> $stable(prot.hsize)
  ) else $error("high size changed while locked");
  load_take_a: assert property (
    ld_state == FCP_LD_WAIT && load_req |=> prot == $past(load_data)
  ) else $error("protection byte not loaded");
  prot_hold_a: assert property (
    ld_state == FCP_LD_DONE && !wr_prot |=> $stable(prot)
  ) else $error("protection changed without write");
  bad_scen_a: assert property (
    wr_prot && !scen_ok |=> $stable(prot)
  ) else $error("disallowed scenario taken");
  prot_wait_a: assert property (
    setup && pwrite && sel_prot |=> !pready
  ) else $error("protection write without wait state");
  prot_read_a: assert property (
    setup && !pwrite && sel_prot |=> pready && prdata == {24'h000000, $past(prot)}
  ) else $error("protection read wrong");
  // command check
  mass_viol_a: assert property (
    cmd_valid && is_mass && !mass_ok |=> protect_violation_flag && cmd_refused
  ) else $error("mass erase not refused");
  mass_ok_a: assert property (
    cmd_valid && is_mass && prot.pol && prot.hdis && prot.ldis |=> cmd_ok && !cmd_refused
  ) else $error("open mass erase refused");
  high_top_a: assert property (
    cmd_valid && !is_mass && prot.pol && !prot.hdis && cmd_addr >= `FCP_HIGH_BASE0 |=> cmd_refused
  ) else $error("top block not protected");
  low_base_a: assert property (
    cmd_valid && !is_mass && prot.pol && !prot.ldis && cmd_addr >= `FCP_LOW_BASE && cmd_addr <= `FCP_LOW_END0
    |=> cmd_refused
  ) else $error("base block not protected");
  full_prot_a: assert property (
    cmd_valid && !is_mass && !prot.pol && prot.hdis && prot.ldis |=> cmd_refused
  ) else $error("full protection not applied");
  open_prot_a: assert property (
    cmd_valid && !is_mass && prot.pol && prot.hdis && prot.ldis |=> cmd_ok
  ) else $error("command refused without protection");
  viol_set_a: assert property (
    cmd_valid && refuse |=> protect_violation_flag && cmd_refused && !cmd_ok
  ) else $error("refusal not flagged");
  viol_hold_a: assert property (
    protect_violation_flag && !clr_viol |=> protect_violation_flag
  ) else $error("violation flag lost");
  // main scenarios
  cfg_write_c: cover property (wr_cfg);
  prot_write_c: cover property (wr_prot && scen_ok);
  refuse_c: cover property (cmd_valid && refuse);
  irq_c: cover property (irq);
  load_c: cover property (ld_state == FCP_LD_WAIT && load_req);
endmodule : fcp_regs_top

/* bench/tb_fcp_regs_top.sv */
// self-checking testbench of the flash config/protection register block
`timescale 1ns/1ps
`include "fcp_regs.svh"
module tb_fcp_regs_top;
  import fcp_pkg::*;
  localparam logic [7:0] A_CFG = {2'b00, `FCP_IDX_CONFIG, 2'b00};
  localparam logic [7:0] A_PROT = {2'b00, `FCP_IDX_PROT, 2'b00};
  localparam logic [7:0] A_STAT = {2'b00, `FCP_IDX_STATUS, 2'b00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, load_done, cmd_ok, cmd_refused, protect_violation_flag;
  logic buffer_empty_flag = 1'b0, all_done_flag = 1'b0, load_req = 1'b0, cmd_valid = 1'b0;
  logic [1:0] backdoor_enable_field = 2'h0, cmd_kind = 2'h0;
  logic [7:0] load_data = 8'h00;
  logic [15:0] cmd_addr = 16'h0000;
  logic array_wr = 1'b0, array_rd = 1'b0;
  logic key_word_strobe, cmd_seq_start, array_rd_invalid, irq;
  int fails = 0;
  int compares = 0;
  logic [7:0] rd;
  logic err;

  always #50 pclk = ~pclk;

  fcp_regs_top i_fcp_regs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .buffer_empty_flag(buffer_empty_flag), .all_done_flag(all_done_flag),
    .backdoor_enable_field(backdoor_enable_field), .load_req(load_req), .load_data(load_data),
    .load_done(load_done), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_ok(cmd_ok), .cmd_refused(cmd_refused), .protect_violation_flag(protect_violation_flag),
    .array_wr(array_wr), .array_rd(array_rd), .key_word_strobe(key_word_strobe),
    .cmd_seq_start(cmd_seq_start), .array_rd_invalid(array_rd_invalid), .irq(irq));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // request held until the edge that samples pready high; a wedged slave is left to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [1:0] k, input logic [15:0] a, input logic ok);
    @(posedge pclk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    @(posedge pclk);
    cmd_valid <= 1'b0;
    @(posedge pclk);
    check("cmd_ok", {15'h0, cmd_ok}, {15'h0, ok});
    check("cmd_refused", {15'h0, cmd_refused}, {15'h0, ~ok});
  endtask : cmd

  task automatic prot_wr(input logic [7:0] d, input logic [7:0] exp);
    apb(1'b1, A_PROT, d);
    apb(1'b0, A_PROT, 8'h00);
    check("protection", {8'h00, rd}, {8'h00, exp});
  endtask : prot_wr

  task automatic t_load;
    apb(1'b0, A_PROT, 8'h00);
    check("prot before load", {8'h00, rd}, 16'h00FF);
    @(posedge pclk);
    load_req <= 1'b1;
    load_data <= 8'hE7;
    @(posedge pclk);
    load_req <= 1'b0;
    load_data <= 8'h00;
    @(posedge pclk);
    check("load_done", {15'h0, load_done}, 16'h0001);
    // a second load must not disturb the loaded value
    load_req <= 1'b1;
    @(posedge pclk);
    load_req <= 1'b0;
    apb(1'b0, A_PROT, 8'h00);
    check("prot after load", {8'h00, rd}, 16'h00E7);
  endtask : t_load

  task automatic t_config;
    logic [1:0] enc [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    for (int i = 0; i < 4; i++) begin
      backdoor_enable_field <= `FCP_KEY_ENABLED;
      apb(1'b1, A_CFG, 8'h00);
      backdoor_enable_field <= enc[i];
      apb(1'b1, A_CFG, 8'hFF);
      apb(1'b0, A_CFG, 8'h00);
      check("config", {8'h00, rd}, (enc[i] == 2'h2) ? 16'h00E0 : 16'h00C0);
    end
    apb(1'b0, 8'h3C, 8'h00);
    check("unmapped err", {15'h0, err}, 16'h0001);
    check("unmapped data", {8'h00, rd}, 16'h0000);
    // key gate is set here; a disabled field must not let it clear either
    backdoor_enable_field <= 2'h1;
    apb(1'b1, A_CFG, 8'h00);
    apb(1'b0, A_CFG, 8'h00);
    check("key gate held", {8'h00, rd}, 16'h0020);
    backdoor_enable_field <= `FCP_KEY_ENABLED;
    apb(1'b1, A_CFG, 8'h00);
  endtask : t_config

  task automatic array_op(input logic w, input logic [2:0] exp);
    @(posedge pclk);
    array_wr <= w;
    array_rd <= ~w;
    @(posedge pclk);
    array_wr <= 1'b0;
    array_rd <= 1'b0;
    @(posedge pclk);
    check("steering", {13'h0, key_word_strobe, cmd_seq_start, array_rd_invalid}, {13'h0, exp});
  endtask : array_op

  task automatic t_steer;
    array_op(1'b1, 3'b010);
    array_op(1'b0, 3'b000);
    backdoor_enable_field <= `FCP_KEY_ENABLED;
    apb(1'b1, A_CFG, 8'h20);
    array_op(1'b1, 3'b100);
    array_op(1'b0, 3'b001);
    apb(1'b1, A_CFG, 8'h00);
  endtask : t_steer

  task automatic t_irq;
    logic [7:0] cv [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_CFG, cv[c]);
      for (int f = 0; f < 4; f++) begin
        buffer_empty_flag <= f[1];
        all_done_flag <= f[0];
        repeat (3) @(posedge pclk);
        check("irq", {15'h0, irq}, {15'h0, (cv[c][7] & f[1]) | (cv[c][6] & f[0])});
      end
    end
    buffer_empty_flag <= 1'b0;
    all_done_flag <= 1'b0;
  endtask : t_irq

  task automatic t_protect;
    cmd(`FCP_CMD_MASS_ERASE, 16'h4000, 1'b1);
    cmd(`FCP_CMD_PROGRAM, 16'h4000, 1'b1);
    prot_wr(8'hFC, 8'hFC);
    prot_wr(8'hF9, 8'hF9);
    prot_wr(8'hFA, 8'hF9);
    prot_wr(8'hFD, 8'hF9);
    cmd(`FCP_CMD_PROGRAM, `FCP_PROT_STORE_ADDR, 1'b1);
    cmd(`FCP_CMD_PROGRAM, 16'h4000, 1'b0);
    cmd(`FCP_CMD_PROGRAM, 16'h43FF, 1'b0);
    cmd(`FCP_CMD_SECTOR_ERASE, 16'h4400, 1'b1);
    cmd(`FCP_CMD_MASS_ERASE, 16'h4400, 1'b0);
    check("violation", {15'h0, protect_violation_flag}, 16'h0001);
    apb(1'b1, A_STAT, 8'h20);
    // the clear lands at the edge that ends the write
    @(posedge pclk);
    check("violation clear", {15'h0, protect_violation_flag}, 16'h0000);
    prot_wr(8'hD9, 8'hD9);
    cmd(`FCP_CMD_PROGRAM, 16'hC000, 1'b0);
    cmd(`FCP_CMD_PROGRAM, 16'hBFFF, 1'b1);
    cmd(`FCP_CMD_PROGRAM, 16'hFFFF, 1'b0);
    prot_wr(8'hC1, 8'hD9);
    prot_wr(8'h7D, 8'h7D);
    prot_wr(8'hFD, 8'h7D);
    cmd(`FCP_CMD_PROGRAM, 16'h8000, 1'b0);
  endtask : t_protect

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_load();
    t_config();
    t_steer();
    t_irq();
    t_protect();
    complete_run();
  end

  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    complete_run();
  end
endmodule : tb_fcp_regs_top
